// ### core/gpio_led_pin_config.sv
// Pin configuration, data and interrupt detection for three GPIO/LED pins
// and the two shared EEPROM pins, behind an AXI4-Lite register port.
// Assumes EEPROM, LED and MII signals arrive on sys_clk; pads resolve oe.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
module gpio_led_pin_config #(
   parameter int FILTER = gpio_led_pkg::FILTER_CYCLES
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [gpio_led_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [gpio_led_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [2:0] gpio_in,
   output logic [2:0] gpio_out,
   output logic [2:0] gpio_oe,
   input wire logic eeprom_data_pin_in,
   output logic eeprom_data_pin_out,
   output logic eeprom_data_pin_oe,
   output logic eeprom_clock_pin_out,
   output logic eeprom_clock_pin_oe,
   input wire logic ee_data_out,
   input wire logic ee_data_oe,
   input wire logic ee_clock_out,
   output logic ee_data_in,
   input wire logic [2:0] led_activity,
   input wire logic mii_tx_en,
   input wire logic mii_rx_dv,
   input wire logic mii_tx_clk,
   input wire logic mii_rx_clk,
   output logic [2:0] pin_irq_pending
);
   import gpio_led_pkg::*;

   localparam logic [4:0] FILTER_LAST = 5'(FILTER);
   localparam logic [2:0] INIT_LAST = 3'(INIT_WAIT_CYCLES);

   // Bus handshake state
   logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
   logic awready_reg, wready_reg, arready_reg;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg, w_data_reg;
   logic [11:0] aw_addr_reg;
   logic [3:0] w_strb_reg;

   // Block state
   logic [2:0] init_cnt_reg;
   logic init_done_reg;
   logic [31:0] cfg_word_reg, cfg_word_next;
   logic [2:0] out_data_reg, out_data_next, irq_status_reg, irq_status_next;
   logic [2:0] irq_enable_reg, irq_enable_next;
   logic [2:0][4:0] filt_cnt_reg, filt_cnt_next;

   // Output registers
   logic [2:0] gpio_out_reg, gpio_oe_reg, pending_reg;
   logic ee_dio_out_reg, ee_dio_oe_reg, ee_clk_out_reg, ee_clk_oe_reg, ee_data_in_reg;

   // Combinational nets
   logic aw_hs, w_hs, b_hs, ar_hs, r_hs, write_fire;
   logic wr_sel_cfg, wr_sel_status, wr_sel_enable, wr_mapped, rd_mapped, eeprom_level;
   logic [31:0] rd_word;
   logic [3:0] pad_level;
   logic [2:0] gpio_level, pin_value, pin_drive_en, level_match, irq_set, irq_clear;
   pin_cfg_type cfg;
   pad_drive_type dio_drive, clk_drive;

   // Pad inputs cross into sys_clk before any decision
   // input synchronisation
   pin_sync #(
      .WIDTH(4)
   ) u_pad_sync (
      .clk(sys_clk),
      .arst_n(arst_n),
      .async_in({eeprom_data_pin_in, gpio_in}),
      .level_out(pad_level)
   );

   assign gpio_level = pad_level[2:0];
   assign eeprom_level = pad_level[3];
   assign cfg = cfg_unpack(cfg_word_reg);

   // Channel handshakes
   assign aw_hs = s_axi_awvalid & awready_reg;
   assign w_hs = s_axi_wvalid & wready_reg;
   assign b_hs = bvalid_reg & s_axi_bready;
   assign ar_hs = s_axi_arvalid & arready_reg;
   assign r_hs = rvalid_reg & s_axi_rready;
   assign aw_full_next = (aw_full_reg | aw_hs) & ~b_hs;
   assign w_full_next = (w_full_reg | w_hs) & ~b_hs;
   assign write_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
   assign bvalid_next = write_fire | (bvalid_reg & ~s_axi_bready);
   assign rvalid_next = ar_hs | (rvalid_reg & ~r_hs);

   // Write address decode
   assign wr_sel_cfg = write_fire & word_match(aw_addr_reg, REG_CFG_OFFSET);
   assign wr_sel_status = write_fire & word_match(aw_addr_reg, REG_IRQ_STATUS_OFFSET);
   assign wr_sel_enable = write_fire & word_match(aw_addr_reg, REG_IRQ_ENABLE_OFFSET);
   assign wr_mapped = wr_sel_cfg | wr_sel_status | wr_sel_enable;

   // Reserved and data bits never land in the stored config word
   // reserved bits masked
   assign cfg_word_next = wr_sel_cfg ?
      (apply_strobe(cfg_word_reg, w_data_reg, w_strb_reg) & CFG_WRITE_MASK) :
      cfg_word_reg;

   // Data latch follows the pins until the synchroniser settles
   // data reset from pin
   assign out_data_next = !init_done_reg ? gpio_level :
                          (wr_sel_cfg && w_strb_reg[0]) ? w_data_reg[2:0] :
                          out_data_reg;

   assign irq_enable_next = (wr_sel_enable && w_strb_reg[0]) ?
                            w_data_reg[IRQ_LSB +: 3] : irq_enable_reg;

   // Read data: config word shows live pin levels in the data bits
   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_mapped = 1'b1;
      if (word_match(s_axi_araddr, REG_CFG_OFFSET))
      begin
         rd_word = cfg_word_reg | {29'h0000_0000, gpio_level};
      end
      else if (word_match(s_axi_araddr, REG_IRQ_STATUS_OFFSET))
      begin
         rd_word[IRQ_LSB +: 3] = irq_status_reg;
      end
      else if (word_match(s_axi_araddr, REG_IRQ_ENABLE_OFFSET))
      begin
         rd_word[IRQ_LSB +: 3] = irq_enable_reg;
      end
      else
      begin
         rd_mapped = 1'b0;
      end
   end

   // Level detection; LED pins take no part
   // polarity selects active level
   assign level_match = ~(gpio_level ^ cfg.pin_irq_polarity) & ~cfg.led_select_bits;

   // A level must persist before it counts, so glitches do not latch
   always_comb
   begin
      filt_cnt_next = filt_cnt_reg;
      irq_set = 3'h0;
      for (int i = 0; i < 3; i++)
      begin
         if (!level_match[i])
         begin
            filt_cnt_next[i] = 5'h00;
         end
         else if (filt_cnt_reg[i] != FILTER_LAST)
         begin
            filt_cnt_next[i] = filt_cnt_reg[i] + 5'h01;
         end
         irq_set[i] = level_match[i] && (filt_cnt_reg[i] == FILTER_LAST);
      end
   end

   // Set beats a clear landing in the same cycle
   // write one clears status
   assign irq_clear = (wr_sel_status && w_strb_reg[0]) ? w_data_reg[IRQ_LSB +: 3] : 3'h0;
   assign irq_status_next = irq_set | (irq_status_reg & ~irq_clear);

   // GPIO pad drive: LED mode overrides the data latch
   // LED select
   assign pin_value = (cfg.led_select_bits & led_activity) |
                      (~cfg.led_select_bits & out_data_reg);
   assign pin_drive_en = cfg.led_select_bits | cfg.pin_direction_bits;

   // EEPROM pin routing; reserved codes fall back to the EEPROM lines
   always_comb
   begin
      case (cfg.eeprom_pin_function_field)
         FN_GPO_BOTH:
         begin
            dio_drive = '{out: cfg.general_output_data_bits[0], oe: 1'b1};
            clk_drive = '{out: cfg.general_output_data_bits[1], oe: 1'b1};
         end
         FN_GENERAL_OUTPUT_3_RXDV:
         begin
            dio_drive = '{out: cfg.general_output_data_bits[0], oe: 1'b1};
            clk_drive = '{out: mii_rx_dv, oe: 1'b1};
         end
         FN_TXEN_GENERAL_OUTPUT_4:
         begin
            dio_drive = '{out: mii_tx_en, oe: 1'b1};
            clk_drive = '{out: cfg.general_output_data_bits[1], oe: 1'b1};
         end
         FN_TXEN_RXDV:
         begin
            dio_drive = '{out: mii_tx_en, oe: 1'b1};
            clk_drive = '{out: mii_rx_dv, oe: 1'b1};
         end
         FN_MII_CLOCKS:
         begin
            dio_drive = '{out: mii_tx_clk, oe: 1'b1};
            clk_drive = '{out: mii_rx_clk, oe: 1'b1};
         end
         default:
         begin
            dio_drive = '{out: ee_data_out, oe: ee_data_oe};
            clk_drive = '{out: ee_clock_out, oe: 1'b1};
         end
      endcase
   end

   // Bus channel registers
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         awready_reg <= init_done_reg & ~aw_full_next;
         wready_reg <= init_done_reg & ~w_full_next;
         bvalid_reg <= bvalid_next;
         if (write_fire)
         begin
            bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         arready_reg <= init_done_reg & ~rvalid_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // Bus payload captures
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         aw_addr_reg <= 12'h000;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end
      else
      begin
         if (aw_hs)
         begin
            aw_addr_reg <= s_axi_awaddr;
         end
         if (w_hs)
         begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (ar_hs)
         begin
            rdata_reg <= rd_word;
            rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Register file and detection state
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         init_cnt_reg <= 3'h0;
         init_done_reg <= 1'b0;
         cfg_word_reg <= CFG_RESET;
         out_data_reg <= 3'h0;
         irq_status_reg <= IRQ_STATUS_RESET;
         irq_enable_reg <= IRQ_ENABLE_RESET;
         filt_cnt_reg <= '0;
      end
      else
      begin
         if (init_cnt_reg != INIT_LAST)
         begin
            init_cnt_reg <= init_cnt_reg + 3'h1;
         end
         init_done_reg <= init_cnt_reg == INIT_LAST;
         cfg_word_reg <= cfg_word_next;
         out_data_reg <= out_data_next;
         irq_status_reg <= irq_status_next;
         irq_enable_reg <= irq_enable_next;
         filt_cnt_reg <= filt_cnt_next;
      end
   end

   // Pad and sideband outputs, all registered
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         gpio_out_reg <= 3'h0;
         gpio_oe_reg <= 3'h0;
         ee_dio_out_reg <= 1'b0;
         ee_dio_oe_reg <= 1'b0;
         ee_clk_out_reg <= 1'b0;
         ee_clk_oe_reg <= 1'b0;
         ee_data_in_reg <= 1'b0;
         pending_reg <= 3'h0;
      end
      else
      begin
         gpio_out_reg <= pin_value;
         gpio_oe_reg <= pin_drive_en & (cfg.pin_buffer_type_bits | ~pin_value);
         ee_dio_out_reg <= dio_drive.out;
         ee_dio_oe_reg <= dio_drive.oe;
         ee_clk_out_reg <= clk_drive.out;
         ee_clk_oe_reg <= clk_drive.oe;
         ee_data_in_reg <= eeprom_level;
         pending_reg <= irq_status_reg & irq_enable_reg;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign gpio_out = gpio_out_reg;
   assign gpio_oe = gpio_oe_reg;
   assign eeprom_data_pin_out = ee_dio_out_reg;
   assign eeprom_data_pin_oe = ee_dio_oe_reg;
   assign eeprom_clock_pin_out = ee_clk_out_reg;
   assign eeprom_clock_pin_oe = ee_clk_oe_reg;
   assign ee_data_in = ee_data_in_reg;
   assign pin_irq_pending = pending_reg;

endmodule // gpio_led_pin_config

// ### core/gpio_led_pkg.sv
// Constants, field layout and carrier types for the pin configuration block.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register port.
// Overview of operation
// - LED select bit turns pin into LED
// - Polarity bit picks level that sets status
// - Pin interrupt forwarded only when enabled
// - Function field 000 keeps EEPROM pins
// - Function codes route GPO, MII signals
// - Buffer bit selects push-pull or open-drain
// - Direction bit one makes pin output
// - General output bits drive outputs 3,4
// - Output data drives pin; read returns pin
// - Config resets zero; data from pin
// - Status bits clear on write one
package gpio_led_pkg;

   localparam int AXI_ADDR_W = 12;
   localparam logic [11:0] REG_CFG_OFFSET = 12'h0d0;
   localparam logic [11:0] REG_IRQ_STATUS_OFFSET = 12'h0c0;
   localparam logic [11:0] REG_IRQ_ENABLE_OFFSET = 12'h0c4;

   localparam int LED_LSB = 28;
   localparam int POL_LSB = 24;
   localparam int FN_LSB = 20;
   localparam int BUF_LSB = 16;
   localparam int DIR_LSB = 8;
   localparam int GPO_LSB = 3;
   localparam int IRQ_LSB = 4;

   localparam logic [31:0] CFG_WRITE_MASK = 32'h7777_0718;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [2:0] IRQ_STATUS_RESET = 3'h0;
   localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;

   localparam logic [2:0] FN_EEPROM = 3'h0;
   localparam logic [2:0] FN_GPO_BOTH = 3'h1;
   localparam logic [2:0] FN_GENERAL_OUTPUT_3_RXDV = 3'h3;
   localparam logic [2:0] FN_TXEN_GENERAL_OUTPUT_4 = 3'h5;
   localparam logic [2:0] FN_TXEN_RXDV = 3'h6;
   localparam logic [2:0] FN_MII_CLOCKS = 3'h7;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam int CLK_PERIOD_PS = 4000;
   localparam int MIN_ACTIVE_NS = 80;
   localparam int SYNC_STAGES = 3;
   localparam int MIN_ACTIVE_CYCLES = (MIN_ACTIVE_NS * 1000) / CLK_PERIOD_PS;
   localparam int FILTER_CYCLES = MIN_ACTIVE_CYCLES - SYNC_STAGES - 1;
   localparam int INIT_WAIT_CYCLES = SYNC_STAGES + 1;

   typedef struct packed {
      logic [2:0] led_select_bits;
      logic [2:0] pin_irq_polarity;
      logic [2:0] eeprom_pin_function_field;
      logic [2:0] pin_buffer_type_bits;
      logic [2:0] pin_direction_bits;
      logic [1:0] general_output_data_bits;
   } pin_cfg_type;

   typedef struct packed {
      logic out;
      logic oe;
   } pad_drive_type;

   function automatic pin_cfg_type cfg_unpack(input logic [31:0] word);
      pin_cfg_type c;
      c.led_select_bits = word[LED_LSB +: 3];
      c.pin_irq_polarity = word[POL_LSB +: 3];
      c.eeprom_pin_function_field = word[FN_LSB +: 3];
      c.pin_buffer_type_bits = word[BUF_LSB +: 3];
      c.pin_direction_bits = word[DIR_LSB +: 3];
      c.general_output_data_bits = word[GPO_LSB +: 2];
      return c;
   endfunction

   function automatic logic [31:0] apply_strobe(input logic [31:0] old_word,
                                                input logic [31:0] new_word,
                                                input logic [3:0] strb);
      logic [31:0] r;
      r = old_word;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[8*i +: 8] = new_word[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic word_match(input logic [11:0] addr, input logic [11:0] offset);
      return addr[11:2] == offset[11:2];
   endfunction

endpackage

// ### core/pin_sync.sv
// Three-stage synchroniser with agreement filter for pad inputs.
// Assumes inputs are asynchronous to clk; output is a registered level.
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;
   logic [WIDTH-1:0] level_reg;
   logic [WIDTH-1:0] agree;
   logic [WIDTH-1:0] level_next;

   // Only a value seen on two late stages counts
   assign agree = ~(stage2_reg ^ stage3_reg);
   assign level_next = (agree & stage2_reg) | (~agree & level_reg);
   assign level_out = level_reg;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
         level_reg <= '0;
      end
      else
      begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         level_reg <= level_next;
      end
   end
endmodule // pin_sync

// ### verif/board_pins_model.sv
// Board side of the pads: pull-ups, outside drivers and the serial memory line.
// Assumes device pads drive while oe is high; outside drive is bench-controlled.
`timescale 1ns/10ps
module board_pins_model (
   input wire logic [2:0] gpio_out,
   input wire logic [2:0] gpio_oe,
   input wire logic [2:0] ext_val,
   input wire logic [2:0] ext_en,
   input wire logic ee_pin_out,
   input wire logic ee_pin_oe,
   input wire logic ee_dev_out,
   output logic [2:0] gpio_in,
   output logic ee_pin_in
);
   assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ((ext_en & ext_val) | ~ext_en));
   assign ee_pin_in = ee_pin_oe ? ee_pin_out : ee_dev_out;
endmodule // board_pins_model

// ### verif/gpio_led_pin_config_assertions.sv
// Port-level checker for the pin configuration block.
// Assumes it is bound onto gpio_led_pin_config and sees its ports only.
`timescale 1ns/10ps
module gpio_led_pin_config_assertions #(
   parameter int FILTER = gpio_led_pkg::FILTER_CYCLES
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [gpio_led_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [gpio_led_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [2:0] gpio_oe,
   input wire logic eeprom_clock_pin_oe,
   input wire logic [2:0] pin_irq_pending
);
   import gpio_led_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   function automatic logic mapped(input logic [11:0] a);
      return a[11:2] inside {REG_CFG_OFFSET[11:2], REG_IRQ_STATUS_OFFSET[11:2],
                             REG_IRQ_ENABLE_OFFSET[11:2]};
   endfunction

   wire aw_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire aw_map = mapped(s_axi_awaddr);
   wire ar_map = mapped(s_axi_araddr);

   AST_RST_INIT: assert property ($rose(arst_n) |-> (gpio_oe == 3'h0 &&
      pin_irq_pending == 3'h0 && !s_axi_arready) [*4] ##[1:4] s_axi_arready)
      else $error("outputs not quiet or ready timing wrong after reset");
   AST_AW_REFUSED: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
      else $error("write address accepted while a write is open");
   AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address ready while read data pending");
   AST_B_LATENCY: assert property (aw_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not two cycles after request");
   AST_R_LATENCY: assert property (ar_take |=> s_axi_rvalid)
      else $error("read data not one cycle after request");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before accepted");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before accepted");
   AST_WR_UNMAPPED: assert property (aw_take && !aw_map |=> ##1
      s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not answered with slave error");
   AST_RD_UNMAPPED: assert property (ar_take && !ar_map |=>
      s_axi_rdata == 32'h0 && s_axi_rresp == RESP_SLVERR)
      else $error("unmapped read not zero with slave error");
   AST_CLK_OE: assert property ($past(arst_n) |-> eeprom_clock_pin_oe)
      else $error("shared clock pin released");

   cover property (pin_irq_pending != 3'h0);
   cover property (aw_take && !aw_map);
   cover property (s_axi_rvalid && s_axi_rready);
endmodule // gpio_led_pin_config_assertions

bind gpio_led_pin_config gpio_led_pin_config_assertions #(.FILTER(FILTER)) chk_u (
   .sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .gpio_oe, .eeprom_clock_pin_oe, .pin_irq_pending
);

// ### verif/gpio_led_pin_config_tb.sv
// Self-checking bench for the pin configuration block over AXI4-Lite.
// Assumes the board model on the pads; bench drives memory and MII sources.
`timescale 1ns/10ps
module gpio_led_pin_config_tb;
   import gpio_led_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [2:0] gpio_in, gpio_out, gpio_oe, pin_irq_pending;
   logic [2:0] ext_val = 3'h5, ext_en = 3'h7, led_activity = 3'h5;
   logic ed_in, ed_out, ed_oe, ec_out, ec_oe, ee_data_in, eoe, lvl;
   logic ee_data_out = 1'b0, ee_data_oe = 1'b0, ee_clock_out = 1'b0, ee_ext = 1'b1;
   logic tx_en = 1'b0, rx_dv = 1'b0, tx_clk = 1'b0, rx_clk = 1'b0;
   logic [1:0] e;
   logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
   int num_errors = 0, check_count = 0, cycles = 0;
   int p;

   initial forever #2 sys_clk = ~sys_clk;

   gpio_led_pin_config dut_u (
      .sys_clk(sys_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .eeprom_data_pin_in(ed_in), .eeprom_data_pin_out(ed_out), .eeprom_data_pin_oe(ed_oe),
      .eeprom_clock_pin_out(ec_out), .eeprom_clock_pin_oe(ec_oe),
      .ee_data_out(ee_data_out), .ee_data_oe(ee_data_oe), .ee_clock_out(ee_clock_out),
      .ee_data_in(ee_data_in), .led_activity(led_activity), .mii_tx_en(tx_en),
      .mii_rx_dv(rx_dv), .mii_tx_clk(tx_clk), .mii_rx_clk(rx_clk),
      .pin_irq_pending(pin_irq_pending)
   );

   board_pins_model board_u (
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_val(ext_val), .ext_en(ext_en),
      .ee_pin_out(ed_out), .ee_pin_oe(ed_oe), .ee_dev_out(ee_ext), .gpio_in(gpio_in),
      .ee_pin_in(ed_in)
   );

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Hang guard, well above run length
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 8000)
      begin
         num_errors++;
         results();
      end
   end

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Address and data offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ap, wp;
      ap = 1'b1;
      wp = 1'b1;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (ap || wp)
      begin
         @(posedge sys_clk);
         if (ap && awready === 1'b1)
         begin
            ap = 1'b0;
            awvalid <= 1'b0;
         end
         if (wp && wready === 1'b1)
         begin
            wp = 1'b0;
            wvalid <= 1'b0;
         end
      end
      do @(posedge sys_clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({32'h0, bresp}, {32'h0, er});
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [1:0] er);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk({rresp, rdata}, {er, x});
   endtask

   task automatic pins(input logic [5:0] x);
      tick(3);
      chk({28'h0, gpio_oe, gpio_out}, {28'h0, x});
   endtask

   initial
   begin
      tick(6);
      arst_n <= 1'b1;
      rd(REG_CFG_OFFSET, 32'h5, RESP_OKAY);
      rd(REG_IRQ_STATUS_OFFSET, 32'h0, RESP_OKAY);
      rd(REG_IRQ_ENABLE_OFFSET, 32'h0, RESP_OKAY);
      pins(6'h05);
      $display("test reset done");
      ext_en <= 3'h0;
      wr(REG_CFG_OFFSET, 32'h0007_0702, RESP_OKAY);
      pins(6'h3a);
      rd(REG_CFG_OFFSET, 32'h0007_0702, RESP_OKAY);
      wr(REG_CFG_OFFSET, 32'h0000_0702, RESP_OKAY);
      pins(6'h2a);
      rd(REG_CFG_OFFSET, 32'h0000_0702, RESP_OKAY);
      wr(REG_CFG_OFFSET, 32'h0000_0302, RESP_OKAY);
      pins(6'h0a);
      rd(REG_CFG_OFFSET, 32'h0000_0306, RESP_OKAY);
      $display("test direction done");
      wr(REG_CFG_OFFSET, 32'h7007_0000, RESP_OKAY);
      pins(6'h3d);
      wr(REG_CFG_OFFSET, 32'h2000_0007, RESP_OKAY);
      pins(6'h15);
      rd(REG_CFG_OFFSET, 32'h2000_0005, RESP_OKAY);
      $display("test led done");
      // memory lines stepped through four patterns, reserved codes never written
      foreach (codes[i])
      begin
         for (p = 0; p < 4; p++)
         begin
            ee_data_out <= p[0];
            ee_clock_out <= p[1];
            ee_data_oe <= p[1];
            ee_ext <= !p[0];
            tx_en <= !p[0];
            tx_clk <= !p[1];
            rx_dv <= !p[1];
            rx_clk <= !p[0];
            wr(REG_CFG_OFFSET, {9'h0, codes[i], 15'h0, p[0], p[1], 3'h0}, RESP_OKAY);
            tick(6);
            case (codes[i])
               3'h0: e = {p[0], p[1]};
               3'h1: e = {p[1], p[0]};
               3'h3: e = {p[1], !p[1]};
               3'h5: e = {!p[0], p[0]};
               3'h6: e = {!p[0], !p[1]};
               default: e = {!p[1], !p[0]};
            endcase
            eoe = (codes[i] == FN_EEPROM) ? p[1] : 1'b1;
            lvl = eoe ? e[1] : !p[0];
            chk({30'h0, ed_oe, ed_out, ec_out, ee_data_in}, {30'h0, eoe, e, lvl});
         end
      end
      $display("test pin function done");
      ext_en <= 3'h7;
      ext_val <= 3'h3;
      wr(REG_CFG_OFFSET, 32'h0400_0000, RESP_OKAY);
      tick(30);
      wr(REG_IRQ_STATUS_OFFSET, 32'h70, RESP_OKAY);
      wr(REG_IRQ_ENABLE_OFFSET, 32'h70, RESP_OKAY);
      rd(REG_IRQ_STATUS_OFFSET, 32'h0, RESP_OKAY);
      ext_val <= 3'h7;
      tick(10);
      ext_val <= 3'h3;
      tick(30);
      rd(REG_IRQ_STATUS_OFFSET, 32'h0, RESP_OKAY);
      wr(REG_CFG_OFFSET, 32'h0100_0000, RESP_OKAY);
      tick(40);
      rd(REG_IRQ_STATUS_OFFSET, 32'h50, RESP_OKAY);
      chk({31'h0, pin_irq_pending}, 34'h5);
      wr(REG_IRQ_ENABLE_OFFSET, 32'h10, RESP_OKAY);
      pins(6'h00);
      chk({31'h0, pin_irq_pending}, 34'h1);
      wr(REG_CFG_OFFSET, 32'h0400_0000, RESP_OKAY);
      tick(5);
      wr(REG_IRQ_STATUS_OFFSET, 32'h0, RESP_OKAY);
      rd(REG_IRQ_STATUS_OFFSET, 32'h50, RESP_OKAY);
      wr(REG_IRQ_STATUS_OFFSET, 32'h10, RESP_OKAY);
      rd(REG_IRQ_STATUS_OFFSET, 32'h40, RESP_OKAY);
      chk({31'h0, pin_irq_pending}, 34'h0);
      $display("test interrupt done");
      wr(REG_CFG_OFFSET, 32'hffff_ffff, RESP_OKAY);
      tick(5);
      rd(REG_CFG_OFFSET, 32'h7777_071d, RESP_OKAY);
      wr(12'h0e0, 32'h1, RESP_SLVERR);
      rd(12'h0e0, 32'h0, RESP_SLVERR);
      $display("test reserved done");
      results();
   end
endmodule // gpio_led_pin_config_tb
